/* File: hdl/dog_reset_flag_top.sv */
/*
 * watchdog timer with timed unlock and reset-cause flags behind apb.
 * assumes reset sources arrive as pins from outside core_clk, the fuse is
 * a static pin, and the cpu acknowledges the vector via a command write.
 */
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dog_reset_flag_consts.svh"
module dog_reset_flag_top #(
    parameter int UNLOCK_CYCLES = `DOG_RESET_FLAG_UNLOCK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_in,
    input wire logic safety_level_fuse,
    input wire logic global_irq_enable,
    input wire logic power_on_seen,
    input wire logic brownout_seen,
    input wire logic pin_reset_seen,
    output logic dog_reset_pulse,
    output logic timeout_irq
);
    import dog_reset_flag_pkg::*;

    initial begin
        if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES > 15) $error("unlock window out of range");
    end

    // ==========================================================
    // pin synchronisers for reset sources and fuse
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic por_s;
    logic bor_s;
    logic pin_s;
    logic level2;

    // no reset here: the fuse level must already stand when rst falls,
    // or a level 2 part would run unguarded for two cycles
    always_ff @(posedge core_clk) begin
        s1_reg <= {safety_level_fuse, pin_reset_seen, brownout_seen, power_on_seen};
        s2_reg <= s1_reg;
    end
    assign por_s = s2_reg[0];
    assign bor_s = s2_reg[1];
    assign pin_s = s2_reg[2];
    assign level2 = s2_reg[3];

    // ==========================================================
    // apb decode
    dog_reset_flag_tick_if tk ();
    logic wr_en;
    logic rd_en;
    logic known;
    dog_reset_flag_byte_t wb;

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
        addr_is = (a == ref_a);
    endfunction

    assign known = addr_is(paddr, `DOG_RESET_FLAG_ADDR_CAUSE) || addr_is(paddr, `DOG_RESET_FLAG_ADDR_CTRL)
        || addr_is(paddr, `DOG_RESET_FLAG_ADDR_CMD);
    assign wr_en = psel && penable && pwrite && known;
    assign rd_en = psel && penable && !pwrite;
    assign wb = pwdata[7:0];

    logic wr_ctrl;
    logic wr_cause;
    logic wr_cmd;
    assign wr_ctrl = wr_en && addr_is(paddr, `DOG_RESET_FLAG_ADDR_CTRL);
    assign wr_cause = wr_en && addr_is(paddr, `DOG_RESET_FLAG_ADDR_CAUSE);
    assign wr_cmd = wr_en && addr_is(paddr, `DOG_RESET_FLAG_ADDR_CMD);

    // ==========================================================
    // control state
    logic guard_reg;
    logic irq_en_reg;
    logic irq_flag_reg;
    logic unlock_reg;
    logic [3:0] unlock_cnt_reg;
    dog_reset_flag_period_t period_reg;
    logic [3:0] cause_reg;
    logic expire;
    logic guard_eff;
    logic kick;
    logic vec_ack;
    dog_reset_flag_action_e action;

    assign kick = wr_cmd && wb[`DOG_RESET_FLAG_CMD_KICK];
    assign vec_ack = wr_cmd && wb[`DOG_RESET_FLAG_CMD_VECACK];
    assign expire = tk.expire;

    // level 2 always runs; level 1 forced on by dog flag
    assign guard_eff = level2 || guard_reg || cause_reg[`DOG_RESET_FLAG_CAUSE_DOG];

    always_comb begin
        case ({guard_eff, irq_en_reg})
            2'b00: action = DOG_RESET_FLAG_ACT_NONE;
            2'b01: action = DOG_RESET_FLAG_ACT_IRQ;
            2'b10: action = DOG_RESET_FLAG_ACT_RESET;
            2'b11: action = DOG_RESET_FLAG_ACT_IRQ_FIRST;
            default: action = DOG_RESET_FLAG_ACT_NONE;
        endcase
    end

    // unlock window, counted on core_clk from the setting write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            unlock_reg <= 1'b0;
            unlock_cnt_reg <= 4'h0;
        end else if (wr_ctrl && wb[`DOG_RESET_FLAG_CTRL_UNLOCK] && wb[`DOG_RESET_FLAG_CTRL_GUARD]) begin
            unlock_reg <= 1'b1;
            unlock_cnt_reg <= 4'(UNLOCK_CYCLES);
        end else if (wr_ctrl && unlock_reg) begin
            unlock_reg <= 1'b0; // second write consumes the window
            unlock_cnt_reg <= 4'h0;
        end else if (unlock_cnt_reg == 4'h1) begin
            unlock_reg <= 1'b0;
            unlock_cnt_reg <= 4'h0;
        end else if (unlock_cnt_reg != 4'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 4'h1;
        end
    end

    // guard_enable and period
    logic second_write;
    assign second_write = wr_ctrl && unlock_reg && !wb[`DOG_RESET_FLAG_CTRL_UNLOCK];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            guard_reg <= 1'b0;
            period_reg <= 4'h0;
        end else if (wr_ctrl) begin
            if (wb[`DOG_RESET_FLAG_CTRL_GUARD]) begin
                guard_reg <= 1'b1;
            end else if (second_write && !level2) begin
                guard_reg <= 1'b0;
            end
            // level 1 changes period freely; level 2 only through the window
            if (!level2 || second_write) begin
                period_reg <= {wb[`DOG_RESET_FLAG_CTRL_PER3], wb[2:0]};
            end
        end
    end

    // interrupt enable and flag
    logic irq_hit;
    assign irq_hit = expire && (action == DOG_RESET_FLAG_ACT_IRQ || action == DOG_RESET_FLAG_ACT_IRQ_FIRST);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_en_reg <= 1'b0;
        end else if (expire && guard_eff) begin
            irq_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            irq_en_reg <= wb[`DOG_RESET_FLAG_CTRL_IRQ_EN];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_flag_reg <= 1'b0;
        end else if (irq_hit) begin
            irq_flag_reg <= 1'b1; // set wins over clear
        end else if (vec_ack || (wr_ctrl && wb[`DOG_RESET_FLAG_CTRL_IRQ_FLAG])) begin
            irq_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            timeout_irq <= 1'b0;
        end else begin
            timeout_irq <= irq_flag_reg && irq_en_reg && global_irq_enable;
        end
    end

    // reset pulse: only when the action is plain reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dog_reset_pulse <= 1'b0;
        end else begin
            dog_reset_pulse <= expire && action == DOG_RESET_FLAG_ACT_RESET;
        end
    end

    // ==========================================================
    // reset-cause flags; set beats software clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cause_reg <= 4'h0;
        end else begin
            if (expire && action == DOG_RESET_FLAG_ACT_RESET) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_DOG] <= 1'b1;
            end else if (por_s || (wr_cause && !wb[`DOG_RESET_FLAG_CAUSE_DOG])) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_DOG] <= 1'b0;
            end
            if (bor_s) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_BROWN] <= 1'b1;
            end else if (por_s || (wr_cause && !wb[`DOG_RESET_FLAG_CAUSE_BROWN])) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_BROWN] <= 1'b0;
            end
            if (pin_s) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_PIN] <= 1'b1;
            end else if (por_s || (wr_cause && !wb[`DOG_RESET_FLAG_CAUSE_PIN])) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_PIN] <= 1'b0;
            end
            if (por_s) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_POWER] <= 1'b1;
            end else if (wr_cause && !wb[`DOG_RESET_FLAG_CAUSE_POWER]) begin
                cause_reg[`DOG_RESET_FLAG_CAUSE_POWER] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // counter hookup
    assign tk.running = guard_eff || irq_en_reg;
    assign tk.count_clear = kick || expire;
    // reserved codes are clamped to the longest period rather than misbehaving
    assign tk.period = (period_reg > `DOG_RESET_FLAG_PERIOD_MAX) ? `DOG_RESET_FLAG_PERIOD_MAX : period_reg;

    dog_reset_flag_osc_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .osc_in(osc_in),
        .osc_tick(tk.osc_tick)
    );

    dog_reset_flag_counter #(.CW(21)) u_cnt (
        .core_clk(core_clk),
        .rst(rst),
        .tk(tk)
    );

    // ==========================================================
    // apb answer, zero wait states
    dog_reset_flag_byte_t rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (addr_is(paddr, `DOG_RESET_FLAG_ADDR_CAUSE)) begin
            rd_byte = {4'h0, cause_reg};
        end else if (addr_is(paddr, `DOG_RESET_FLAG_ADDR_CTRL)) begin
            rd_byte = {irq_flag_reg, irq_en_reg, period_reg[3], unlock_reg, guard_eff,
                period_reg[2:0]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

/* File: include/dog_reset_flag_consts.svh */
/*
 * offsets, field positions, reset values and timing counts of the watchdog
 * and reset-cause block; assumes inclusion through its bare name.
 */
`ifndef DOG_RESET_FLAG_CONSTS_SVH
`define DOG_RESET_FLAG_CONSTS_SVH

// ==========================================================
// register byte addresses on the apb bus
`define DOG_RESET_FLAG_ADDR_CAUSE 12'h000
`define DOG_RESET_FLAG_ADDR_CTRL 12'h004
`define DOG_RESET_FLAG_ADDR_CMD 12'h008

// ==========================================================
// watchdog_control_status fields
`define DOG_RESET_FLAG_CTRL_IRQ_FLAG 7
`define DOG_RESET_FLAG_CTRL_IRQ_EN 6
`define DOG_RESET_FLAG_CTRL_PER3 5
`define DOG_RESET_FLAG_CTRL_UNLOCK 4
`define DOG_RESET_FLAG_CTRL_GUARD 3

// ==========================================================
// reset_cause_status fields
`define DOG_RESET_FLAG_CAUSE_DOG 3
`define DOG_RESET_FLAG_CAUSE_BROWN 2
`define DOG_RESET_FLAG_CAUSE_PIN 1
`define DOG_RESET_FLAG_CAUSE_POWER 0

// ==========================================================
// command register fields (kick and vector acknowledge)
`define DOG_RESET_FLAG_CMD_KICK 0
`define DOG_RESET_FLAG_CMD_VECACK 1

// ==========================================================
// timing
`define DOG_RESET_FLAG_UNLOCK_CYCLES 4
`define DOG_RESET_FLAG_BASE_CYCLES 2048
`define DOG_RESET_FLAG_PERIOD_MAX 4'h9
`define DOG_RESET_FLAG_CTRL_RESET 8'h00

`endif

/* File: include/dog_reset_flag_pkg.sv */
/*
 * types shared by the watchdog block; assumes nothing of its surroundings.
 */
package dog_reset_flag_pkg;
    typedef logic [7:0] dog_reset_flag_byte_t;
    typedef logic [3:0] dog_reset_flag_period_t;
    typedef enum logic [1:0] {
        DOG_RESET_FLAG_ACT_NONE,
        DOG_RESET_FLAG_ACT_IRQ,
        DOG_RESET_FLAG_ACT_RESET,
        DOG_RESET_FLAG_ACT_IRQ_FIRST
    } dog_reset_flag_action_e;
endpackage

/* File: include/dog_reset_flag_tick_if.sv */
/*
 * carries the watchdog oscillator tick and counter control between the
 * top module and its counter; assumes one clock.
 */
`timescale 1ns/1ps
interface dog_reset_flag_tick_if;
    logic osc_tick;
    logic count_clear;
    logic running;
    logic [3:0] period;
    logic expire;
    modport ctl (output count_clear, output running, output period, input osc_tick,
        input expire);
    modport cnt (input count_clear, input running, input period, output osc_tick,
        output expire);
endinterface

/* File: hdl/dog_reset_flag_osc_sync.sv */
/*
 * brings the free running oscillator level into core_clk and turns each
 * rising edge into a one-cycle tick; assumes the oscillator is far slower
 * than core_clk.
 */
`timescale 1ns/1ps
module dog_reset_flag_osc_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic osc_in,
    output logic osc_tick
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            osc_tick <= 1'b0;
        end else begin
            sync1_reg <= osc_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            osc_tick <= sync2_reg & ~prev_reg;
        end
    end
endmodule

/* File: hdl/dog_reset_flag_counter.sv */
/*
 * counts watchdog oscillator ticks and pulses expire when the selected
 * period elapses; assumes the period code is already legal.
 */
`timescale 1ns/1ps
`include "dog_reset_flag_consts.svh"
module dog_reset_flag_counter #(
    parameter int CW = 21
) (
    input wire logic core_clk,
    input wire logic rst,
    dog_reset_flag_tick_if.cnt tk
);
    import dog_reset_flag_pkg::*;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] limit;

    initial begin
        if (CW < 21) $error("counter too narrow for longest period");
    end

    assign limit = CW'((`DOG_RESET_FLAG_BASE_CYCLES << tk.period) - 1);

    always_ff @(posedge core_clk) begin
        if (rst || tk.count_clear || !tk.running) begin
            count_reg <= '0;
            tk.expire <= 1'b0;
        end else if (tk.osc_tick) begin
            tk.expire <= (count_reg == limit);
            count_reg <= (count_reg == limit) ? '0 : count_reg + 1'b1;
        end else begin
            tk.expire <= 1'b0;
        end
    end
endmodule

/* File: dv/dog_reset_flag_top_properties.sv */
/*
 * concurrent checks on the apb answer, read data and watchdog outputs of
 * dog_reset_flag_top; assumes the master holds psel and penable until pready.
 */
`timescale 1ns/1ps
module dog_reset_flag_top_properties #(
    parameter int UNLOCK_CYCLES = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_in,
    input wire logic safety_level_fuse,
    input wire logic global_irq_enable,
    input wire logic power_on_seen,
    input wire logic brownout_seen,
    input wire logic pin_reset_seen,
    input wire logic dog_reset_pulse,
    input wire logic timeout_irq
);
    // ==========
    // apb phases
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_read;
        s_access ##0 !pwrite;
    endsequence
    // ==========
    // checks
    a_apb_answer: assert property (s_setup |=> s_access)
        else $error("no access answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_ready_phase: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_error_map: assert property (pready |-> pslverr == (paddr[11:2] > 10'h002))
        else $error("pslverr does not match the address map");
    a_upper_zero: assert property (s_read |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_cause_reserved: assert property (s_read ##0 paddr == 12'h000 |-> prdata[7:4] == 4'h0)
        else $error("reserved cause bits not zero");
    a_level2_guard: assert property (s_read ##0 paddr == 12'h004 && safety_level_fuse |-> prdata[3])
        else $error("guard_enable reads zero at level 2");
    a_pulse_single: assert property (dog_reset_pulse |=> !dog_reset_pulse)
        else $error("reset pulse longer than one cycle");
    a_irq_global: assert property (timeout_irq |-> $past(global_irq_enable))
        else $error("interrupt without global enable");
endmodule
bind dog_reset_flag_top dog_reset_flag_top_properties #(.UNLOCK_CYCLES(UNLOCK_CYCLES)) u_dog_reset_flag_top_properties (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .osc_in, .safety_level_fuse, .global_irq_enable, .power_on_seen,
    .brownout_seen, .pin_reset_seen, .dog_reset_pulse, .timeout_irq
);

/* File: dv/dog_reset_flag_tb_top.sv */
/*
 * self-checking bench for dog_reset_flag_top: apb master, reset sources, fast
 * watchdog oscillator; assumes the one-wait-free apb access of the design.
 */
`timescale 1ns/1ps
`include "dog_reset_flag_consts.svh"
module dog_reset_flag_tb_top;
    localparam logic [11:0] CAU = `DOG_RESET_FLAG_ADDR_CAUSE;
    localparam logic [11:0] CTL = `DOG_RESET_FLAG_ADDR_CTRL;
    localparam logic [11:0] CMD = `DOG_RESET_FLAG_ADDR_CMD;
    localparam logic [32:0] ERR = 33'h100000000;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, osc_in = 0;
    logic fuse = 0, gie = 0, pready, pslverr, dog_reset_pulse, timeout_irq;
    logic [2:0] src = 0, div = 0;
    logic [3:0] p;
    logic [7:0] d;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [32:0] exp_q[$];
    int bad_count = 0, check_count = 0, seed = 32'h89c7, n;

    dog_reset_flag_top u_dog_reset_flag_top (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_in(osc_in),
        .safety_level_fuse(fuse), .global_irq_enable(gie),
        .power_on_seen(src[2]), .brownout_seen(src[1]), .pin_reset_seen(src[0]),
        .dog_reset_pulse(dog_reset_pulse), .timeout_irq(timeout_irq)
    );

    // ==========
    // clocks; oscillator at one eighth of core_clk keeps time-outs short
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        div <= div + 3'h1;
        osc_in <= div[2];
    end

    // ==========
    // checking and closing
    task check(input logic [32:0] seen, input logic [32:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());

    // ==========
    // drivers; upper write bits are random junk the design must ignore
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] v);
        int k;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($random(seed)), v};
        @(posedge core_clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(0, a, 8'h00);
    endtask
    task idle(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task poke(input logic [2:0] s);
        @(posedge core_clk);
        src <= s;
        idle(5);
        src <= 0;
    endtask
    task wait_for(input bit irq, input int lo, input int hi);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while ((irq ? timeout_irq : dog_reset_pulse) !== 1'b1 && n < hi);
        check(33'(n >= lo && n < hi), 33'h1);
    endtask

    // ==========
    // scenarios
    initial begin
        idle(8);
        rst <= 0;
        rd(CAU, 0);
        rd(CTL, 0);
        rd(12'h00c + 12'({$random(seed)} & 32'h3fc), ERR);
        poke(3'b001);
        rd(CAU, 8'h02);
        poke(3'b010);
        rd(CAU, 8'h06);
        poke(3'b100);
        rd(CAU, 8'h01);
        poke(3'b011);
        apb(1, CAU, 8'h01);
        rd(CAU, 8'h01);
        apb(1, CAU, 8'hf0);
        rd(CAU, 0);
        apb(1, CTL, 8'h08);
        rd(CTL, 8'h08);
        apb(1, CTL, 0);
        rd(CTL, 8'h08);
        apb(1, CTL, 8'h18);
        apb(1, CTL, 0);
        rd(CTL, 0);
        apb(1, CTL, 8'h18);
        idle(6);
        apb(1, CTL, 0);
        rd(CTL, 8'h08);
        repeat (3) begin
            p = 4'({$random(seed)} % 10);
            d = {2'b00, p[3], 2'b01, p[2:0]};
            apb(1, CTL, d);
            rd(CTL, 33'(d));
        end
        apb(1, CTL, 8'h18);
        apb(1, CTL, 0);
        apb(1, CTL, 8'h08);
        wait_for(0, 16360, 16410);
        rd(CAU, 8'h08);
        apb(1, CTL, 8'h18);
        apb(1, CTL, 0);
        rd(CTL, 8'h08);
        apb(1, CAU, 0);
        apb(1, CTL, 8'h18);
        apb(1, CTL, 0);
        rd(CTL, 0);
        gie <= 1;
        apb(1, CTL, 8'h40);
        idle(8000);
        apb(1, CMD, 8'h01);
        wait_for(1, 16360, 16410);
        rd(CTL, 8'hc0);
        gie <= 0;
        idle(2);
        check(33'(timeout_irq), 0);
        gie <= 1;
        apb(1, CMD, 8'h02);
        rd(CTL, 8'h40);
        apb(1, CTL, 0);
        apb(1, CTL, 8'h48);
        idle(16500);
        rd(CTL, 8'h88);
        wait_for(0, 16230, 16310);
        apb(1, CTL, 8'h88);
        rd(CTL, 8'h08);
        rst <= 1;
        fuse <= 1;
        idle(8);
        rst <= 0;
        rd(CTL, 8'h08);
        apb(1, CTL, 0);
        rd(CTL, 8'h08);
        apb(1, CTL, 8'h02);
        rd(CTL, 8'h08);
        apb(1, CTL, 8'h18);
        apb(1, CTL, 8'h01);
        rd(CTL, 8'h09);
        apb(1, CTL, 8'h18);
        apb(1, CTL, 0);
        rd(CTL, 8'h08);
        idle(4);
        complete_run();
    end
    initial begin
        #4500000;
        check(0, 1);
        complete_run();
    end
endmodule
